// ===== design/ric_top.sv
// reset and interrupt controller top
`timescale 1ns/1ps
module ric_top #(
  parameter int PORL_CYC = ric_pkg::PORL_CYCLES,
  parameter int WDOG_CYC = ric_pkg::WDOG_CYCLES,
  parameter bit MASK_WD_EN = 1'b1
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // pins
  input wire logic RESET_N_PIN,
  input wire logic EXT_INT_N_PIN,
  input wire logic LOW_VOLT_N_PIN,
  // peripheral flags
  input wire logic T16_FLAG,
  input wire logic KEY_FLAG,
  // core interface
  input wire logic OP_FETCH,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic INSTR_DONE,
  input wire logic TRAP_EXEC,
  input wire logic RETURN_EXEC,
  input wire logic STACKED_MASK,
  input wire logic MASK_CLEAR,
  input wire logic MASK_SET,
  input wire logic MEM_WR,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic CORE_RST,
  output logic INT_TAKE,
  output logic [15:0] VECTOR,
  output logic MASK_BIT,
  output logic WD_RESET_FLAG,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [2:0] s1_q, s2_q, s1_d, s2_d;
  always_comb begin
    s1_d = {LOW_VOLT_N_PIN, EXT_INT_N_PIN, RESET_N_PIN};
    s2_d = s1_q;
  end
  always_ff @(posedge REF_CLK) begin
    s1_q <= s1_d;
    s2_q <= s2_d;
  end
  logic rst_pin_lo, ext_lo, lvi_lo;
  assign rst_pin_lo = ~s2_q[0];
  assign ext_lo = ~s2_q[1];
  assign lvi_lo = ~s2_q[2];

  function automatic logic legal_fetch(input logic [15:0] a,
                                       input logic prog);
    logic lo_ok;
    lo_ok = prog ? (a >= ric_pkg::EPROM_LO) : (a >= ric_pkg::ROM_LO);
    legal_fetch = (a >= ric_pkg::RAM_LO && a <= ric_pkg::RAM_HI) ||
                  (a >= ric_pkg::EE_LO && a <= ric_pkg::EE_HI) ||
                  (lo_ok && a <= ric_pkg::PROG_HI);
  endfunction

  // ************************************************
  // reset sequencing
  // ************************************************
  ric_pkg::ric_state_t st_q, st_d;
  logic [31:0] por_q, por_d;
  logic [31:0] wd_q, wd_d;
  logic [1:0] plo_q, plo_d;
  logic illegal_q, illegal_d;
  logic wdr_q, wdr_d;
  logic wd_exp, pin_rst, hard_rst;
  logic [7:0] ctrl_q, ctrl_d;
  logic wd_on;
  assign wd_on = ctrl_q[ric_pkg::B_PROG_PART] ?
                 ctrl_q[ric_pkg::B_WD_EN] : MASK_WD_EN;
  assign pin_rst = (plo_q >= ric_pkg::RST_MIN_CYC[1:0]);
  assign wd_exp = wd_on && (wd_q >= WDOG_CYC - 1);
  assign hard_rst = SYS_RST | pin_rst | (por_q != 32'h0);
  always_comb begin
    plo_d = rst_pin_lo ?
            ((plo_q == 2'h3) ? plo_q : plo_q + 2'h1) : 2'h0;
    por_d = (por_q != 32'h0) ? por_q - 32'h1 : por_q;
    wd_d = wd_q + 32'h1;
    if (MEM_WR && MEM_ADDR == ric_pkg::WDOG_ADDR &&
        !MEM_WDATA[0]) begin
      wd_d = 32'h0;
    end
    if (wd_exp || CORE_RST) begin
      wd_d = 32'h0;
    end
    illegal_d = OP_FETCH && !legal_fetch(FETCH_ADDR,
                ctrl_q[ric_pkg::B_PROG_PART]);
    wdr_d = wd_exp ? 1'b1 : (hard_rst ? 1'b0 : wdr_q);
    st_d = (hard_rst || rst_pin_lo || wd_exp || illegal_q) ?
           ric_pkg::ST_RESET : ric_pkg::ST_RUN;
  end
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      por_q <= PORL_CYC[31:0];
      plo_q <= 2'h0;
      wd_q <= 32'h0;
      illegal_q <= 1'b0;
      wdr_q <= 1'b0;
      st_q <= ric_pkg::ST_RESET;
    end else begin
      por_q <= por_d;
      plo_q <= plo_d;
      wd_q <= wd_d;
      illegal_q <= illegal_d;
      wdr_q <= wdr_d;
      st_q <= st_d;
    end
  end
  assign CORE_RST = (st_q == ric_pkg::ST_RESET);
  assign WD_RESET_FLAG = wdr_q;

  // ************************************************
  // core timer
  // ************************************************
  logic [7:0] ct_q, ct_d, rdiv_q, rdiv_d, rcnt_q, rcnt_d;
  logic rtf_q, rtf_d, ovf_q, ovf_d;
  logic [7:0] en_q, en_d;
  logic [7:0] fclr;
  assign fclr = (REG_WR && REG_ADDR == ric_pkg::A_FLAG) ?
                REG_WDATA : 8'h00;
  always_comb begin
    ct_d = ct_q + 8'h01;
    rcnt_d = rcnt_q + 8'h01;
    rtf_d = rtf_q & ~fclr[1];
    ovf_d = ovf_q & ~fclr[2];
    if (rcnt_q >= rdiv_q) begin
      rcnt_d = 8'h00;
      if (en_q[1]) begin
        rtf_d = 1'b1;
      end
    end
    if (ct_q == ric_pkg::CT_MAX && en_q[2]) begin
      ovf_d = 1'b1;
    end
    rdiv_d = (REG_WR && REG_ADDR == ric_pkg::A_CT) ? REG_WDATA : rdiv_q;
  end
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ct_q <= 8'h00;
      rcnt_q <= 8'h00;
      rtf_q <= 1'b0;
      ovf_q <= 1'b0;
      rdiv_q <= ric_pkg::RTI_DIV_DEF;
    end else begin
      ct_q <= ct_d;
      rcnt_q <= rcnt_d;
      rtf_q <= rtf_d;
      ovf_q <= ovf_d;
      rdiv_q <= rdiv_d;
    end
  end

  // ************************************************
  // external and low-voltage latches
  // ************************************************
  logic ext_prev_q, ext_lat_q, ext_lat_d;
  logic lvi_prev_q, lvi_lat_q, lvi_lat_d;
  logic ext_fall, lvi_edge, ext_ack;
  assign ext_fall = ext_lo && !ext_prev_q;
  assign lvi_edge = (lvi_lo != lvi_prev_q) && !CORE_RST;
  always_comb begin
    ext_lat_d = ext_fall | (ext_lat_q & ~ext_ack & ~fclr[0]);
    lvi_lat_d = lvi_edge |
                (lvi_lat_q & ~ctrl_q[ric_pkg::B_LVI_CLR]);
  end
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ext_prev_q <= 1'b0;
      ext_lat_q <= 1'b0;
      lvi_prev_q <= 1'b0;
      lvi_lat_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_lo;
      ext_lat_q <= ext_lat_d;
      lvi_prev_q <= lvi_lo;
      lvi_lat_q <= lvi_lat_d;
    end
  end

  // ************************************************
  // requests, priority and mask
  // ************************************************
  logic [ric_pkg::NSRC-1:0] flag, req;
  logic ext_req;
  assign ext_req = ext_lat_q |
                   (ctrl_q[ric_pkg::B_EXT_LEVEL] & ext_lo);
  assign flag = {KEY_FLAG, T16_FLAG, lvi_lat_q,
                 (rtf_q & en_q[1]) | (ovf_q & en_q[2]),
                 ext_req};
  genvar g;
  generate
    for (g = 0; g < ric_pkg::NSRC; g++) begin : g_req
      localparam int EI = (g == 1) ? 1 : ((g == 0) ? 0 : g + 1);
      if (g == 1) begin : g_ct
        assign req[g] = flag[g];
      end else begin : g_o
        assign req[g] = flag[g] & en_q[EI];
      end
    end
  endgenerate
  logic mask_q, mask_d, take;
  logic [15:0] vec_q, vec_d;
  always_comb begin
    vec_d = vec_q;
    take = 1'b0;
    if (INSTR_DONE) begin
      if (TRAP_EXEC && (mask_q || req == '0)) begin
        take = 1'b1;
        vec_d = ric_pkg::VEC_TRAP;
      end else if (!mask_q && req != '0) begin
        take = 1'b1;
        if (req[0]) vec_d = ric_pkg::VEC_EXT;
        else if (req[1]) vec_d = ric_pkg::VEC_CTIM;
        else if (req[2]) vec_d = ric_pkg::VEC_LVI;
        else if (req[3]) vec_d = ric_pkg::VEC_T16;
        else vec_d = ric_pkg::VEC_KEY;
      end
    end
    mask_d = mask_q;
    if (MASK_CLEAR) mask_d = 1'b0;
    if (RETURN_EXEC) mask_d = STACKED_MASK;
    if (MASK_SET || take) mask_d = 1'b1;
    if (CORE_RST) begin
      mask_d = 1'b1;
      vec_d = ric_pkg::VEC_RESET;
    end
  end
  assign ext_ack = take && vec_d == ric_pkg::VEC_EXT;
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      mask_q <= 1'b1;
      vec_q <= ric_pkg::VEC_RESET;
      INT_TAKE <= 1'b0;
    end else begin
      mask_q <= mask_d;
      vec_q <= vec_d;
      INT_TAKE <= take;
    end
  end
  assign VECTOR = vec_q;
  assign MASK_BIT = mask_q;

  // ************************************************
  // register port
  // ************************************************
  logic [7:0] rd_d, rd_q;
  always_comb begin
    ctrl_d = ctrl_q;
    ctrl_d[ric_pkg::B_LVI_CLR] = 1'b0;
    if (REG_WR && REG_ADDR == ric_pkg::A_CTRL) ctrl_d = REG_WDATA;
    en_d = en_q;
    if (REG_WR && REG_ADDR == ric_pkg::A_EN) en_d = REG_WDATA;
    if (hard_rst) en_d = 8'h00;
    unique case (REG_ADDR)
      ric_pkg::A_CTRL: rd_d = ctrl_q & ~8'h04;
      ric_pkg::A_EN: rd_d = en_q;
      ric_pkg::A_FLAG: rd_d = {3'h0, lvi_lat_q, 1'b0, ovf_q, rtf_q,
                               ext_lat_q};
      ric_pkg::A_CT: rd_d = ct_q;
      ric_pkg::A_STAT: rd_d = {5'h00, wdr_q, mask_q, s2_q[2]};
      default: rd_d = 8'h00;
    endcase
    if (!REG_RD) rd_d = 8'h00;
  end
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ctrl_q <= 8'h00;
      en_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      en_q <= en_d;
      rd_q <= rd_d;
    end
  end
  assign REG_RDATA = rd_q;
endmodule

// ===== design/ric_pkg.sv
// package: constants for the reset and interrupt controller
package ric_pkg;
  localparam logic [15:0] VEC_RESET = 16'h1FFE;
  localparam logic [15:0] VEC_TRAP = 16'h1FFC;
  localparam logic [15:0] VEC_EXT = 16'h1FFA;
  localparam logic [15:0] VEC_CTIM = 16'h1FF8;
  localparam logic [15:0] VEC_LVI = 16'h1FF6;
  localparam logic [15:0] VEC_T16 = 16'h1FF4;
  localparam logic [15:0] VEC_KEY = 16'h1FF2;
  localparam logic [15:0] WDOG_ADDR = 16'h1FF0;
  localparam logic [15:0] RAM_LO = 16'h0080;
  localparam logic [15:0] RAM_HI = 16'h00FF;
  localparam logic [15:0] EE_LO = 16'h0100;
  localparam logic [15:0] EE_HI = 16'h019F;
  localparam logic [15:0] ROM_LO = 16'h0800;
  localparam logic [15:0] EPROM_LO = 16'h0700;
  localparam logic [15:0] PROG_HI = 16'h1FFF;
  localparam logic [7:0] CT_MAX = 8'hFF;
  // register addresses on the plain port
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_EN = 4'h1;
  localparam logic [3:0] A_FLAG = 4'h2;
  localparam logic [3:0] A_CT = 4'h3;
  localparam logic [3:0] A_STAT = 4'h4;
  // control bits
  localparam int B_EXT_LEVEL = 0;
  localparam int B_WD_EN = 1;
  localparam int B_LVI_CLR = 2;
  localparam int B_WD_SVC = 3;
  localparam int B_PROG_PART = 4;
  localparam logic [7:0] RTI_DIV_DEF = 8'h10;
  localparam int NSRC = 5;
  localparam int PORL_CYCLES = 4064;
  localparam int WDOG_CYCLES = 65536;
  localparam int RST_MIN_CYC = 2;
  typedef enum logic [1:0] {ST_RESET, ST_RUN} ric_state_t;
endpackage

// ===== sim/ric_props.sv
// checker: port assertions for the reset and interrupt controller
`timescale 1ns/1ps
module ric_props (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // inputs
  input wire logic RESET_N_PIN,
  input wire logic OP_FETCH,
  input wire logic [15:0] FETCH_ADDR,
  input wire logic INSTR_DONE,
  input wire logic TRAP_EXEC,
  input wire logic RETURN_EXEC,
  input wire logic STACKED_MASK,
  input wire logic MASK_CLEAR,
  input wire logic MASK_SET,
  // outputs
  input wire logic CORE_RST,
  input wire logic INT_TAKE,
  input wire logic [15:0] VECTOR,
  input wire logic MASK_BIT
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SYS_RST);
  a_trap_vector: assert property (
    INSTR_DONE && TRAP_EXEC && !CORE_RST
    |=> INT_TAKE && VECTOR == ric_pkg::VEC_TRAP)
    else $error("trap not vectored");
  a_take_mask: assert property (INT_TAKE |-> MASK_BIT)
    else $error("take without mask set");
  a_take_boundary: assert property (!INSTR_DONE |=> !INT_TAKE)
    else $error("take off boundary");
  a_mask_holds: assert property (
    MASK_BIT && INSTR_DONE && !TRAP_EXEC && !MASK_CLEAR && !RETURN_EXEC
    |=> !INT_TAKE)
    else $error("masked request taken");
  a_return_mask: assert property (
    RETURN_EXEC && !STACKED_MASK && !INSTR_DONE && !MASK_SET && !CORE_RST
    |=> !MASK_BIT || CORE_RST)
    else $error("return kept mask");
  a_reset_vector: assert property (
    $fell(CORE_RST) |-> VECTOR == ric_pkg::VEC_RESET && MASK_BIT)
    else $error("reset exit vector or mask wrong");
  a_illegal_fetch: assert property (
    OP_FETCH && !CORE_RST && FETCH_ADDR > ric_pkg::PROG_HI
    |-> ##[1:3] CORE_RST)
    else $error("illegal fetch no reset");
  a_pin_reset: assert property (
    !RESET_N_PIN [*4] |-> ##[0:3] CORE_RST)
    else $error("pin low no reset");
endmodule

bind ric_top ric_props i_props (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
  .RESET_N_PIN(RESET_N_PIN), .OP_FETCH(OP_FETCH), .FETCH_ADDR(FETCH_ADDR),
  .INSTR_DONE(INSTR_DONE), .TRAP_EXEC(TRAP_EXEC),
  .RETURN_EXEC(RETURN_EXEC), .STACKED_MASK(STACKED_MASK),
  .MASK_CLEAR(MASK_CLEAR), .MASK_SET(MASK_SET), .CORE_RST(CORE_RST),
  .INT_TAKE(INT_TAKE), .VECTOR(VECTOR), .MASK_BIT(MASK_BIT));

// ===== sim/ric_core_model.sv
// partner model: processor core side of the controller
`timescale 1ns/1ps
module ric_core_model (
  // clock
  input wire logic clk,
  // core strobes
  output logic op_fetch,
  output logic [15:0] fetch_addr,
  output logic instr_done,
  output logic trap_exec,
  output logic return_exec,
  output logic stacked_mask,
  output logic mask_clear,
  output logic mem_wr,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata
);
  initial begin
    {op_fetch, instr_done, trap_exec, return_exec} = 4'h0;
    {stacked_mask, mask_clear, mem_wr} = 3'h0;
    fetch_addr = 16'h1000;
    mem_addr = 16'h0000;
    mem_wdata = 8'h00;
  end
  task automatic step(input logic t);
    @(posedge clk);
    instr_done <= 1'b1;
    trap_exec <= t;
    @(posedge clk);
    instr_done <= 1'b0;
    trap_exec <= 1'b0;
  endtask
  task automatic fetch(input logic [15:0] a);
    @(posedge clk);
    op_fetch <= 1'b1;
    fetch_addr <= a;
    @(posedge clk);
    op_fetch <= 1'b0;
    fetch_addr <= ~a;
  endtask
  task automatic ret(input logic s);
    @(posedge clk);
    return_exec <= 1'b1;
    stacked_mask <= s;
    @(posedge clk);
    return_exec <= 1'b0;
    stacked_mask <= ~s;
  endtask
  // service: zero in bit 0 at the service address
  task automatic wd_kick;
    @(posedge clk);
    mem_wr <= 1'b1;
    mem_addr <= ric_pkg::WDOG_ADDR;
    mem_wdata <= 8'h00;
    @(posedge clk);
    mem_wr <= 1'b0;
    mem_addr <= ~ric_pkg::WDOG_ADDR;
    mem_wdata <= 8'hFF;
  endtask
endmodule

// ===== sim/ric_top_bench.sv
// testbench: reset and interrupt controller
`timescale 1ns/1ps
module ric_top_bench;
  logic ref_clk = 1'b0, sys_rst = 1'b1, rst_n = 1'b0, ext_n = 1'b1;
  logic t16 = 1'b0, key = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic lvi_n = 1'b1, mset = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
  logic op_f, done, trap, ret_e, smask, mclr, mem_wr;
  logic [15:0] f_addr, m_addr, vector;
  logic [7:0] m_wdata;
  logic core_rst, int_take, mask_bit, wd_flag;
  int err_count = 0, checked = 0;
  initial begin
    forever #20 ref_clk = ~ref_clk;
  end
  ric_core_model i_core (.clk(ref_clk), .op_fetch(op_f),
    .fetch_addr(f_addr), .instr_done(done), .trap_exec(trap),
    .return_exec(ret_e), .stacked_mask(smask), .mask_clear(mclr),
    .mem_wr(mem_wr), .mem_addr(m_addr), .mem_wdata(m_wdata));
  ric_top #(.PORL_CYC(16), .WDOG_CYC(64), .MASK_WD_EN(1'b0)) i_dut (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .RESET_N_PIN(rst_n),
    .EXT_INT_N_PIN(ext_n), .LOW_VOLT_N_PIN(lvi_n), .T16_FLAG(t16),
    .KEY_FLAG(key), .OP_FETCH(op_f), .FETCH_ADDR(f_addr),
    .INSTR_DONE(done), .TRAP_EXEC(trap), .RETURN_EXEC(ret_e),
    .STACKED_MASK(smask), .MASK_CLEAR(mclr), .MASK_SET(mset),
    .MEM_WR(mem_wr), .MEM_ADDR(m_addr), .MEM_WDATA(m_wdata),
    .CORE_RST(core_rst), .INT_TAKE(int_take), .VECTOR(vector),
    .MASK_BIT(mask_bit), .WD_RESET_FLAG(wd_flag), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata));
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_rst(input logic v, input int lim);
    for (int i = 0; i < lim && core_rst !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("core_rst", v, core_rst);
    if (core_rst !== v) finish_test();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic take(input logic t, input logic [15:0] v);
    i_core.step(t);
    #1;
    chk("int_take", 16'h0001, {15'h0, int_take});
    chk("vector", v, vector);
    chk("mask_bit", 16'h0001, {15'h0, mask_bit});
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (30) @(posedge ref_clk);
    #1 chk("core_rst held", 16'h0001, {15'h0, core_rst});
    rst_n <= 1'b1;
    wait_rst(1'b0, 20);
    chk("reset vector", ric_pkg::VEC_RESET, vector);
    rd(ric_pkg::A_EN, d);
    chk("enables", 16'h0000, {8'h0, d});
    rd(4'hF, d);
    chk("unmapped", 16'h0000, {8'h0, d});
    wr(ric_pkg::A_EN, 8'h31);
    t16 <= 1'b1;
    key <= 1'b1;
    i_core.step(1'b0);
    #1 chk("masked take", 16'h0000, {15'h0, int_take});
    i_core.ret(1'b0);
    take(1'b0, ric_pkg::VEC_T16);
    t16 <= 1'b0;
    i_core.ret(1'b0);
    #1 chk("mask after return", 16'h0000, {15'h0, mask_bit});
    take(1'b0, ric_pkg::VEC_KEY);
    key <= 1'b0;
    take(1'b1, ric_pkg::VEC_TRAP);
    i_core.ret(1'b0);
    ext_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ext_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    take(1'b0, ric_pkg::VEC_EXT);
    i_core.fetch(16'h0080);
    repeat (4) @(posedge ref_clk);
    #1 chk("legal fetch", 16'h0000, {15'h0, core_rst});
    i_core.fetch(16'h2000);
    wait_rst(1'b1, 5);
    wait_rst(1'b0, 20);
    wr(ric_pkg::A_CTRL, 8'h12);
    repeat (3) begin
      repeat (30) @(posedge ref_clk);
      i_core.wd_kick();
    end
    #1 chk("serviced", 16'h0000, {15'h0, core_rst});
    wait_rst(1'b1, 100);
    wait_rst(1'b0, 20);
    chk("wd flag", 16'h0001, {15'h0, wd_flag});
    wr(ric_pkg::A_CTRL, 8'h10);
    wr(ric_pkg::A_EN, 8'h31);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_rst(1'b1, 6);
    wait_rst(1'b0, 20);
    rd(ric_pkg::A_EN, d);
    chk("enables after pin", 16'h0000, {8'h0, d});
    wr(ric_pkg::A_EN, 8'h02);
    i_core.ret(1'b0);
    repeat (20) @(posedge ref_clk);
    rd(ric_pkg::A_FLAG, d);
    chk("rtick flag", 16'h0001, {15'h0, d[1]});
    take(1'b0, ric_pkg::VEC_CTIM);
    wr(ric_pkg::A_EN, 8'h04);
    wr(ric_pkg::A_FLAG, 8'h06);
    repeat (260) @(posedge ref_clk);
    rd(ric_pkg::A_FLAG, d);
    chk("ovf flags", 16'h0002, {14'h0, d[2:1]});
    wr(ric_pkg::A_EN, 8'h08);
    lvi_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rd(ric_pkg::A_FLAG, d);
    chk("lvi latch", 16'h0001, {15'h0, d[4]});
    rd(ric_pkg::A_STAT, d);
    chk("lvi level", 16'h0000, {15'h0, d[0]});
    wr(ric_pkg::A_CTRL, 8'h14);
    rd(ric_pkg::A_FLAG, d);
    chk("lvi cleared", 16'h0000, {15'h0, d[4]});
    i_core.ret(1'b0);
    @(posedge ref_clk);
    mset <= 1'b1;
    @(posedge ref_clk);
    mset <= 1'b0;
    #1 chk("mask set", 16'h0001, {15'h0, mask_bit});
    finish_test();
  end
endmodule
